//--- fbpw_pkg.sv
// Shared constants and types for the flash block-protect and write engine.
// Assumes a 32-bit APB master and an 18-bit word address space.
package fbpw_pkg;

    // Array geometry.
    localparam int unsigned WA_W = 18;
    localparam int unsigned BA_W = 19;
    localparam int unsigned NBLK = 7;
    typedef logic [WA_W-1:0] fbpw_wa_t;
    localparam fbpw_wa_t WA_TOP = 18'h3ffff;

    // First word address of each block, lowest block first.
    localparam fbpw_wa_t BASE_BOT [NBLK] = '{18'h00000, 18'h02000, 18'h03000,
        18'h04000, 18'h10000, 18'h20000, 18'h30000};
    localparam fbpw_wa_t BASE_TOP [NBLK] = '{18'h00000, 18'h10000, 18'h20000,
        18'h30000, 18'h3c000, 18'h3d000, 18'h3e000};
    localparam logic [2:0] BOOT_BLK_BOT = 3'h0;
    localparam logic [2:0] BOOT_BLK_TOP = 3'h6;

    // Register byte offsets.
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_INFO = 8'h0c;

    // Command codes on the lower data lanes.
    localparam logic [7:0] CMD_WSETUP_A = 8'h10;
    localparam logic [7:0] CMD_WSETUP_B = 8'h40;
    localparam logic [7:0] CMD_ESETUP   = 8'h20;
    localparam logic [7:0] CMD_ECONFIRM = 8'hd0;
    localparam logic [7:0] CMD_RD_ARRAY = 8'hff;
    localparam logic [7:0] CMD_IDENTIFY = 8'h90;
    localparam logic [7:0] CMD_CLR_STAT = 8'h50;

    localparam logic [15:0] ALL_ONES  = 16'hffff;
    localparam logic [15:0] ALL_ZEROS = 16'h0000;
    localparam logic [15:0] LANE_LO   = 16'h00ff;

    // Status register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic       busy;
        logic       erase_susp;
        logic       erase_fail;
        logic       write_fail;
        logic       vpp_fault;
        logic [2:0] rsvd;
    } fbpw_status_t;

    typedef enum logic [2:0] {
        RM_ARRAY  = 3'b001,
        RM_ID     = 3'b010,
        RM_STATUS = 3'b100
    } fbpw_rmode_t;

    typedef enum logic [2:0] {
        CS_IDLE   = 3'b001,
        CS_WSETUP = 3'b010,
        CS_ESETUP = 3'b100
    } fbpw_cstate_t;

    typedef enum logic [5:0] {
        ES_IDLE    = 6'b000001,
        ES_PROG    = 6'b000010,
        ES_VERIFY  = 6'b000100,
        ES_PREPROG = 6'b001000,
        ES_ERASE   = 6'b010000,
        ES_EVERIFY = 6'b100000
    } fbpw_estate_t;

endpackage : fbpw_pkg

//--- fbpw_top.sv
// Command interpreter, write/erase engine and array of a seven-block flash.
// Assumes an APB master on pclk and pin levels synchronous to pclk.
//
// Overview of operation
// (R01) Seven blocks; erasing one leaves all other blocks untouched.
// (R02) Boot block alters only with unlock voltage or protect pin, plus valid supply.
// (R03) Host holds boot unlock condition until the boot operation ends.
// (R04) Non-boot blocks alter whenever the programming supply is valid.
// (R05) Two 8KB parameter blocks need only a valid programming supply.
// (R06) Width select picks byte array (512K) or word array (256K).
// (R07) In word mode commands and status use only the lower eight lanes.
// (R08) Array writes store one byte or one word according to width.
// (R09) Write engine counts attempts, verifies each cell, updates status.
// (R10) Erase first programs whole block, then counts erase attempts, sets status.
// (R11) Status is 8 bits; busy and erase-suspended owned by the engine; here erase-suspended is tied to 0.
// (R12) Three error bits: supply fault, write failure, erase failure.
// (R13) Commands steer the engine and choose array, ID or status reads.
// (R14) Commands still accepted while busy, but only a small subset acts.
// (R15) Power-down pin low clears status and returns to array read.
// (R16) Only erase works on blocks; reads and writes reach any location.
// (R17) Bottom-boot word map: boot 0-1FFF, parameters 2000-3FFF, mains above.
// (R18) Top-boot word map: boot from 3E000, parameters 3C000-3DFFF, mains below.
// (R19) Host sends erase setup before erase confirm.
// (R20) Host sends write setup right before each array data cycle.
// (R21) Host sends read-array before expecting array data after writes.
// (R22) Boot change without unlock leaves data intact and sets the failure bit.
`timescale 1ns/100ps
`default_nettype none

module fbpw_top #(
    parameter bit         BOOT_TOP  = 1'b0,
    parameter logic [7:0] MAX_TRIES = 8'h04,
    // Identification bytes; the values are arbitrary.
    parameter logic [7:0] ID_MFR    = 8'h5a,
    parameter logic [7:0] ID_DEV    = 8'ha5,
    parameter logic [7:0] ID_DEV_HI = 8'h3c
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Device pins
    input  wire logic        power_down_unlock_pin,
    input  wire logic        unlock_high_voltage,
    input  wire logic        boot_write_protect_pin,
    input  wire logic        vpp_valid,
    input  wire logic        width_select_n
);
    import fbpw_pkg::*;

    logic [15:0]      mem [2**WA_W];
    logic [BA_W-1:0]  cyc_addr;
    fbpw_rmode_t      rmode;
    fbpw_cstate_t     cstate;
    fbpw_estate_t     estate;
    fbpw_wa_t         e_addr;
    fbpw_wa_t         e_start;
    fbpw_wa_t         e_end;
    logic [15:0]      e_data;
    logic [15:0]      e_mask;
    logic [7:0]       e_tries;
    logic             e_boot;
    logic             e_erase;
    logic             f_vpp, f_wfail, f_efail;
    logic             p_vpp, p_wfail, p_efail;
    fbpw_status_t     status;
    logic             busy;
    logic             pdown;
    logic             unlock;
    logic             byte_mode;
    logic             xfer;
    logic             wr_data;
    logic             mapped;
    logic [7:0]       cmd;
    fbpw_wa_t         cyc_wa;
    logic             cyc_lane;
    logic [2:0]       cyc_blk;
    logic             cyc_boot;
    logic             start_prog, start_erase, seq_err, clr_stat;
    logic [15:0]      mem_rd;
    logic             mem_we;
    logic [15:0]      mem_wd;
    logic [15:0]      rd_word;
    logic [31:0]      next_prdata;

    function automatic fbpw_wa_t blk_base(input logic [2:0] b);
        blk_base = BOOT_TOP ? BASE_TOP[b] : BASE_BOT[b];
    endfunction : blk_base

    // (R17) (R18) block decode per variant
    function automatic logic [2:0] blk_of(input fbpw_wa_t a);
        blk_of = 3'h0;
        for (int i = 1; i < NBLK; i++) begin
            if (a >= blk_base(3'(i))) begin
                blk_of = 3'(i);
            end
        end
    endfunction : blk_of

    function automatic fbpw_wa_t blk_end(input logic [2:0] b);
        blk_end = (b == 3'(NBLK - 1)) ? WA_TOP : fbpw_wa_t'(blk_base(b + 3'h1) - 1'b1);
    endfunction : blk_end

    assign busy      = (estate != ES_IDLE);
    assign pdown     = ~power_down_unlock_pin;
    assign unlock    = unlock_high_voltage | boot_write_protect_pin;
    assign byte_mode = ~width_select_n;
    assign xfer      = psel & penable & pready;
    assign wr_data   = xfer & pwrite & (paddr == OFF_DATA);
    assign mapped    = (paddr == OFF_ADDR) | (paddr == OFF_DATA) |
                       (paddr == OFF_STAT) | (paddr == OFF_INFO);
    // (R07) commands taken from the lower lanes only
    assign cmd       = pwdata[7:0];
    // (R06) byte mode uses the extra low address bit as lane select
    assign cyc_wa    = byte_mode ? cyc_addr[BA_W-1:1] : cyc_addr[WA_W-1:0];
    assign cyc_lane  = byte_mode & cyc_addr[0];
    assign cyc_blk   = blk_of(cyc_wa);
    assign cyc_boot  = (cyc_blk == (BOOT_TOP ? BOOT_BLK_TOP : BOOT_BLK_BOT));
    assign mem_rd    = mem[e_addr];

    // (R11) busy comes only from the engine state
    assign status = '{busy: busy, erase_susp: 1'b0, erase_fail: f_efail,
                      write_fail: f_wfail, vpp_fault: f_vpp, rsvd: 3'h0};

    // (R14) while busy only the status clear is acted on
    always_comb begin
        start_prog  = 1'b0;
        start_erase = 1'b0;
        seq_err     = 1'b0;
        clr_stat    = wr_data & (cmd == CMD_CLR_STAT) & ~pdown;
        if (wr_data & ~busy & ~pdown) begin
            // (R20) data cycle follows write setup
            start_prog = (cstate == CS_WSETUP);
            // (R19) confirm counts only after erase setup
            start_erase = (cstate == CS_ESETUP) & (cmd == CMD_ECONFIRM);
            seq_err     = (cstate == CS_ESETUP) & (cmd != CMD_ECONFIRM);
        end
    end

    // (R13) command interpreter and read source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cstate <= CS_IDLE;
            rmode  <= RM_ARRAY;
        // (R15) power-down returns to array read
        end else if (pdown) begin
            cstate <= CS_IDLE;
            rmode  <= RM_ARRAY;
        end else if (wr_data & ~busy) begin
            cstate <= CS_IDLE;
            if (cstate != CS_IDLE) begin
                rmode <= RM_STATUS;
            end else begin
                case (cmd)
                    CMD_WSETUP_A, CMD_WSETUP_B: begin
                        cstate <= CS_WSETUP;
                        rmode  <= RM_STATUS;
                    end
                    CMD_ESETUP: begin
                        cstate <= CS_ESETUP;
                        rmode  <= RM_STATUS;
                    end
                    // (R21) array data only after read-array
                    CMD_RD_ARRAY: rmode <= RM_ARRAY;
                    CMD_IDENTIFY: rmode <= RM_ID;
                    default:      rmode <= rmode;
                endcase
            end
        end
    end

    // Engine start, attempt loop and abort on lost supply or unlock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            estate  <= ES_IDLE;
            e_addr  <= '0;
            e_start <= '0;
            e_end   <= '0;
            e_data  <= ALL_ZEROS;
            e_mask  <= ALL_ZEROS;
            e_tries <= 8'h0;
            e_boot  <= 1'b0;
            e_erase <= 1'b0;
            p_vpp   <= 1'b0;
            p_wfail <= 1'b0;
            p_efail <= 1'b0;
        end else begin
            p_vpp   <= 1'b0;
            p_wfail <= 1'b0;
            p_efail <= 1'b0;
            if (pdown) begin
                estate <= ES_IDLE;
            end else if (start_prog | start_erase) begin
                e_erase <= start_erase;
                e_boot  <= cyc_boot;
                e_tries <= 8'h1;
                // (R16) writes hit one location, erase covers the block
                e_addr  <= start_prog ? cyc_wa : blk_base(cyc_blk);
                e_start <= blk_base(cyc_blk);
                e_end   <= blk_end(cyc_blk);
                // (R08) byte writes touch one lane, word writes both
                e_mask  <= !byte_mode ? ALL_ONES :
                           (cyc_lane ? ~LANE_LO : LANE_LO);
                e_data  <= !byte_mode ? pwdata[15:0] :
                           {pwdata[7:0], pwdata[7:0]};
                // (R04) (R05) only the supply gates non-boot blocks
                if (!vpp_valid) begin
                    p_vpp   <= 1'b1;
                    p_wfail <= start_prog;
                    p_efail <= start_erase;
                // (R02) (R22) locked boot block refused untouched
                end else if (cyc_boot & ~unlock) begin
                    p_wfail <= start_prog;
                    p_efail <= start_erase;
                end else begin
                    estate <= start_prog ? ES_PROG : ES_PREPROG;
                end
            // (R03) supply lost, or unlock lost during a boot-block operation, aborts it
            end else if (busy & (~vpp_valid | (e_boot & ~unlock))) begin
                estate  <= ES_IDLE;
                p_vpp   <= ~vpp_valid;
                p_wfail <= ~e_erase;
                p_efail <= e_erase;
            end else begin
                case (estate)
                    ES_PROG: estate <= ES_VERIFY;
                    // (R09) verify margin and count attempts
                    ES_VERIFY: begin
                        if ((mem_rd & e_mask) == (e_data & e_mask)) begin
                            estate <= ES_IDLE;
                        end else if (e_tries == MAX_TRIES) begin
                            estate  <= ES_IDLE;
                            p_wfail <= 1'b1;
                        end else begin
                            e_tries <= e_tries + 8'h1;
                            estate  <= ES_PROG;
                        end
                    end
                    // (R10) pre-program every location first, then erase the block
                    ES_PREPROG, ES_ERASE: begin
                        e_addr <= (e_addr == e_end) ? e_start : e_addr + 1'b1;
                        if (e_addr == e_end) begin
                            estate <= (estate == ES_PREPROG) ? ES_ERASE : ES_EVERIFY;
                        end
                    end
                    // (R10) erase attempts counted on any unerased cell
                    ES_EVERIFY: begin
                        if (mem_rd != ALL_ONES) begin
                            e_addr <= e_start;
                            if (e_tries == MAX_TRIES) begin
                                estate  <= ES_IDLE;
                                p_efail <= 1'b1;
                            end else begin
                                e_tries <= e_tries + 8'h1;
                                estate  <= ES_ERASE;
                            end
                        end else if (e_addr == e_end) begin
                            estate <= ES_IDLE;
                        end else begin
                            e_addr <= e_addr + 1'b1;
                        end
                    end
                    default: estate <= ES_IDLE;
                endcase
            end
        end
    end

    // (R01) only addresses inside the chosen block are written
    always_comb begin
        mem_we = (estate == ES_PROG) | (estate == ES_PREPROG) | (estate == ES_ERASE);
        case (estate)
            ES_PROG:    mem_wd = mem_rd & (e_data | ~e_mask);
            ES_PREPROG: mem_wd = ALL_ZEROS;
            ES_ERASE:   mem_wd = ALL_ONES;
            default:    mem_wd = mem_rd;
        endcase
    end

    // The array has no reset: contents survive reset and power-down.
    always_ff @(posedge pclk) begin
        if (mem_we & ~pdown) begin
            mem[e_addr] <= mem_wd;
        end
    end

    // (R12) sticky error bits; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_vpp   <= 1'b0;
            f_wfail <= 1'b0;
            f_efail <= 1'b0;
        end else begin
            // (R15) power-down clears the status register
            f_vpp   <= ~pdown & ((f_vpp & ~clr_stat) | p_vpp);
            f_wfail <= ~pdown & ((f_wfail & ~clr_stat) | p_wfail | seq_err);
            f_efail <= ~pdown & ((f_efail & ~clr_stat) | p_efail | seq_err);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_addr <= '0;
        end else if (xfer & pwrite & (paddr == OFF_ADDR)) begin
            cyc_addr <= pwdata[BA_W-1:0];
        end
    end

    // Device read cycle; status stays on the low lanes, the word-mode device ID uses both.
    always_comb begin
        rd_word = {8'h00, status};
        if (!busy && rmode == RM_ID) begin
            if (cyc_addr[byte_mode ? 1 : 0]) begin
                rd_word = {byte_mode ? 8'h00 : ID_DEV_HI, ID_DEV};
            end else begin
                rd_word = {8'h00, ID_MFR};
            end
        end else if (!busy && rmode == RM_ARRAY) begin
            rd_word = mem[cyc_wa];
            if (byte_mode) begin
                rd_word = {8'h00, cyc_lane ? rd_word[15:8] : rd_word[7:0]};
            end
        end
    end

    always_comb begin
        case (paddr)
            OFF_ADDR: next_prdata = {{(32-BA_W){1'b0}}, cyc_addr};
            OFF_DATA: next_prdata = {16'h0000, rd_word};
            OFF_STAT: next_prdata = {24'h000000, status};
            OFF_INFO: next_prdata = {12'h000, rmode, cstate, e_tries, estate};
            default:  next_prdata = 32'h00000000;
        endcase
    end

    // One wait state: the answer is registered in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule : fbpw_top

`default_nettype wire

//--- fbpw_checker.sv
// Port checker for the flash block: APB answer timing and status read-back.
// Assumes it is bound to fbpw_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module fbpw_checker
    import fbpw_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // Device pins
    input  wire logic        power_down_unlock_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic mapped;
    logic pd_seen;

    assign mapped = (paddr == OFF_ADDR) || (paddr == OFF_DATA) || (paddr == OFF_STAT)
        || (paddr == OFF_INFO);

    // Status must read as zero after power-down until software starts new work.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_seen <= 1'b0;
        end else if (!power_down_unlock_pin) begin
            pd_seen <= 1'b1;
        end else if (pready && pwrite && paddr == OFF_DATA) begin
            pd_seen <= 1'b0;
        end
    end

    sequence access_start;
        psel && penable && !$past(penable);
    endsequence

    sequence stat_read;
        pready && !pwrite && paddr == OFF_STAT;
    endsequence

    chk_one_wait_state: assert property (access_start |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    chk_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_rdata_only_read: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata changed outside a read");
    chk_status_width: assert property (stat_read |-> prdata[31:8] == 24'h0 && prdata[6] == 1'b0
        && prdata[2:0] == 3'h0)
        else $error("status has bits outside its defined fields");
    chk_pd_clear_stat: assert property (pd_seen ##0 stat_read |-> prdata == 32'h0)
        else $error("status not cleared by power-down");
endmodule : fbpw_checker

bind fbpw_top fbpw_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .power_down_unlock_pin(power_down_unlock_pin));

`default_nettype wire

//--- fbpw_host_pins.sv
// Host-side model of the flash control pins, driven from bench requests.
// Assumes pin levels change only on pclk edges, as the device samples them.
`timescale 1ns/100ps
`default_nettype none

module fbpw_host_pins (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Requests from the bench
    input  wire logic want_run,
    input  wire logic want_hv,
    input  wire logic want_wp,
    input  wire logic want_vpp,
    input  wire logic want_word,
    input  wire logic boot_busy,
    // Pins toward the device
    output logic      power_down_unlock_pin,
    output logic      unlock_high_voltage,
    output logic      boot_write_protect_pin,
    output logic      vpp_valid,
    output logic      width_select_n
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_unlock_pin  <= 1'b1;
            unlock_high_voltage    <= 1'b0;
            boot_write_protect_pin <= 1'b0;
            vpp_valid              <= 1'b1;
            width_select_n         <= 1'b1;
        end else begin
            power_down_unlock_pin  <= want_run;
            // The unlock voltage rides on the power-down pin, so it cannot exist while low.
            unlock_high_voltage    <= want_run & (want_hv | (boot_busy & unlock_high_voltage));
            boot_write_protect_pin <= want_wp | (boot_busy & boot_write_protect_pin);
            vpp_valid              <= want_vpp;
            width_select_n         <= want_word;
        end
    end
endmodule : fbpw_host_pins

`default_nettype wire

//--- tb_fbpw_top.sv
// Self-checking bench for the flash block engine, driven over APB.
// Assumes fbpw_top with default parameters and the host pin model beside it.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module tb_fbpw_top;
    import fbpw_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        want_run = 1'b1;
    logic        want_hv = 1'b0;
    logic        want_wp = 1'b0;
    logic        want_vpp = 1'b1;
    logic        want_word = 1'b1;
    logic        boot_busy = 1'b0;
    logic        pd_pin;
    logic        hv_pin;
    logic        wp_pin;
    logic        vpp_pin;
    logic        width_pin;
    logic [31:0] v;
    logic        e;
    int          errors = 0;
    int          checked = 0;

    always #2.5 pclk = ~pclk;

    fbpw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .power_down_unlock_pin(pd_pin), .unlock_high_voltage(hv_pin),
        .boot_write_protect_pin(wp_pin), .vpp_valid(vpp_pin), .width_select_n(width_pin));

    fbpw_host_pins u_host (.pclk(pclk), .presetn(presetn), .want_run(want_run),
        .want_hv(want_hv), .want_wp(want_wp), .want_vpp(want_vpp), .want_word(want_word),
        .boot_busy(boot_busy), .power_down_unlock_pin(pd_pin), .unlock_high_voltage(hv_pin),
        .boot_write_protect_pin(wp_pin), .vpp_valid(vpp_pin), .width_select_n(width_pin));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic x;
        apb(1'b0, a, 32'h0, r, x);
    endtask : rd

    // Erases take thousands of cycles; this poll has no limit of its own, only the watchdog bounds it.
    task automatic wait_idle();
        do rd(OFF_STAT, v); while (v[7] !== 1'b0);
    endtask : wait_idle

    task automatic stat(input logic [7:0] s, input string nm);
        rd(OFF_STAT, v);
        `CHK(nm, {24'h0, s}, v)
        if (s != 8'h00) wr(OFF_DATA, {24'h0, CMD_CLR_STAT});
    endtask : stat

    task automatic prog(input logic [31:0] a, input logic [15:0] d);
        wr(OFF_ADDR, a);
        wr(OFF_DATA, a[4] ? 32'h0000ab10 : 32'h0000ab40);
        wr(OFF_DATA, {16'h0, d});
        wait_idle();
    endtask : prog

    task automatic erase(input logic [31:0] a, input bit wt);
        wr(OFF_ADDR, a);
        wr(OFF_DATA, {24'h0, CMD_ESETUP});
        wr(OFF_DATA, {24'h0, CMD_ECONFIRM});
        if (wt) wait_idle();
    endtask : erase

    task automatic rd_arr(input logic [31:0] a, input logic [15:0] d, input string nm);
        wr(OFF_ADDR, a);
        wr(OFF_DATA, {24'h0, CMD_RD_ARRAY});
        rd(OFF_DATA, v);
        `CHK(nm, {16'h0, d}, v)
    endtask : rd_arr

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        stat(8'h00, "reset status");
        apb(1'b0, 8'h10, 32'h0, v, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, v)
        want_hv   <= 1'b1;
        boot_busy <= 1'b1;
        erase(32'h0, 1'b0);
        wr(OFF_DATA, {24'h0, CMD_RD_ARRAY});
        rd(OFF_DATA, v);
        `CHK("busy read", 32'h80, v)
        wait_idle();
        stat(8'h00, "boot erase hv");
        want_hv   <= 1'b0;
        boot_busy <= 1'b0;
        @(posedge pclk);
        want_wp   <= 1'b1;
        boot_busy <= 1'b1;
        prog(32'h1fff, 16'hc3c3);
        stat(8'h00, "boot prog wp");
        want_wp   <= 1'b0;
        boot_busy <= 1'b0;
        erase(32'h3000, 1'b1);
        prog(32'h3004, 16'h5a5a);
        erase(32'h2000, 1'b1);
        rd_arr(32'h1fff, 16'hc3c3, "boot kept");
        rd_arr(32'h3004, 16'h5a5a, "param kept");
        rd_arr(32'h2000, 16'hffff, "erased low");
        rd_arr(32'h2fff, 16'hffff, "erased high");
        prog(32'h2010, 16'h1234);
        stat(8'h00, "prog ok");
        rd_arr(32'h2010, 16'h1234, "prog data");
        prog(32'h2010, 16'hffff);
        stat(8'h10, "verify fail");
        prog(32'h1fff, 16'h0000);
        stat(8'h10, "boot locked");
        rd_arr(32'h1fff, 16'hc3c3, "boot intact");
        erase(32'h0100, 1'b1);
        stat(8'h20, "boot erase locked");
        wr(OFF_ADDR, 32'h2000);
        wr(OFF_DATA, {24'h0, CMD_ESETUP});
        wr(OFF_DATA, {24'h0, CMD_RD_ARRAY});
        stat(8'h30, "bad confirm");
        want_word <= 1'b0;
        prog(32'h4041, 16'h00a5);
        rd_arr(32'h4041, 16'h00a5, "byte read");
        want_word <= 1'b1;
        rd_arr(32'h2020, 16'ha5ff, "byte lane");
        wr(OFF_DATA, {24'h0, CMD_IDENTIFY});
        wr(OFF_ADDR, 32'h0);
        rd(OFF_DATA, v);
        `CHK("id low", 32'h5a, v)
        wr(OFF_ADDR, 32'h1);
        rd(OFF_DATA, v);
        `CHK("id high", 32'h3ca5, v)
        want_vpp <= 1'b0;
        prog(32'h2100, 16'h0000);
        rd(OFF_STAT, v);
        `CHK("supply fault", 32'h18, v)
        want_vpp <= 1'b1;
        want_run <= 1'b0;
        repeat (3) @(posedge pclk);
        want_run <= 1'b1;
        stat(8'h00, "power-down clear");
        wr(OFF_ADDR, 32'h2010);
        rd(OFF_DATA, v);
        `CHK("array mode", 32'h1234, v)
        complete_run();
    end

    // Three block erases take about 50k cycles; allow close to twice that.
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        $display("Watchdog expired before the tests ended");
        complete_run();
    end
endmodule : tb_fbpw_top

`default_nettype wire
